/* rtl/bmd_pkg.sv */
package bmd_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int GPR_IDX_W = 8;
    localparam int SHARED_GPR_N = 16;
    localparam int BANK_GPR_N = 32;
    localparam int GPR_DEPTH = 144;
    localparam int PTR_BANK_LO = 6;
    localparam logic [5:0] LOC_INDIRECT = 6'h00;
    localparam logic [5:0] LOC_POINTER = 6'h04;
    localparam logic [5:0] LOC_BANKED_LO = 6'h0b;
    localparam logic [5:0] LOC_BANKED_HI = 6'h0e;
    localparam logic [5:0] LOC_FLAGS = 6'h0f;
    localparam logic [5:0] LOC_SHARED_GPR = 6'h10;
    localparam logic [5:0] LOC_BANK_GPR = 6'h20;
    localparam logic [1:0] BANK_TIMER = 2'h1;
    localparam logic [1:0] BANK_SERIAL = 2'h3;
    localparam logic [4:0] SFR_TIMER_BASE = 5'h10;
    localparam logic [4:0] SFR_SERIAL_BASE = 5'h14;
    localparam logic [5:0] LOC_SERIAL_RX = 6'h0b;
    localparam logic [5:0] LOC_TIMER_GAP = 6'h0e;
    localparam logic [3:0] SPC_PORT_A_DIR = 4'h5;
    localparam logic [3:0] SPC_PORT_B_DIR = 4'h6;
    localparam logic [3:0] SPC_PORT_C_DIR = 4'h7;
    localparam logic [3:0] SPC_IR_CTRL = 4'hc;
    localparam logic [3:0] SPC_IR_CYCLE = 4'hd;
    localparam logic [3:0] SPC_IR_DUTY = 4'he;
    localparam logic [3:0] SPC_IR_CARRIER = 4'hf;
    localparam logic [7:0] OPTION_RD_ONES = 8'h80;
    localparam logic [7:0] OPTION_WR_MASK = 8'h7f;
    localparam logic [7:0] IR_CTRL_MASK = 8'hf3;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'h7f;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] IR_RST = 8'h00;

    typedef enum logic [1:0] {TGT_NONE, TGT_PTR, TGT_SFR, TGT_GPR} bmd_tgt_t;

    typedef struct packed {
        bmd_tgt_t kind;
        logic readOnly;
        logic [4:0] sfr;
        logic [GPR_IDX_W-1:0] gpr;
    } bmd_loc_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [4:0] sel;
        logic [DATA_W-1:0] wdata;
    } bmd_sfr_req_t;
endpackage

/* rtl/bmd_sync2.sv */
`timescale 1ns/10ps
module bmd_sync2 import bmd_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk, // system clock
    input wire logic rstn, // sync reset, low
    input wire logic [W-1:0] din, // asynchronous level
    output logic [W-1:0] dout // synchronised level
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
        end
    end

    assign dout = stage2_reg;
endmodule

/* rtl/bmd_gpr_store.sv */
`timescale 1ns/10ps
module bmd_gpr_store import bmd_pkg::*; #(
    parameter int DEPTH = GPR_DEPTH,
    parameter int W = DATA_W,
    parameter int IDX_W = GPR_IDX_W
) (
    input wire logic clk, // system clock
    input wire logic wrEn, // write strobe
    input wire logic [IDX_W-1:0] wrIdx, // write index
    input wire logic [W-1:0] wrData, // write data
    input wire logic [IDX_W-1:0] rdIdx, // read index
    output logic [W-1:0] rdData // read data
);
    logic [W-1:0] mem_reg [DEPTH];

    // no reset: general storage powers up unknown
    always_ff @(posedge clk) begin
        if (wrEn && (int'(wrIdx) < DEPTH)) begin
            mem_reg[wrIdx] <= wrData;
        end
    end

    assign rdData = (int'(rdIdx) < DEPTH) ? mem_reg[rdIdx] : '0;
endmodule

/* rtl/bmd_decoder.sv */
`timescale 1ns/10ps
module bmd_decoder import bmd_pkg::*; (
    input wire logic clk, // 10 MHz system clock
    input wire logic rstn, // sync reset, low
    input wire logic cfgBankingEn, // banking config bit, async
    input wire logic memWe, // data memory write
    input wire logic memRe, // data memory read
    input wire logic [ADDR_W-1:0] memAddr, // direct file address
    input wire logic [DATA_W-1:0] memWdata, // write data, all ports
    input wire logic bankSetEn, // bank instruction
    input wire logic [1:0] bankSetVal, // bank from instruction
    input wire logic optWe, // option write instruction
    input wire logic optRe, // option read instruction
    input wire logic dirWe, // direction write instruction
    input wire logic dirRe, // direction read instruction
    input wire logic [3:0] dirAddr, // direction/infrared index
    input wire logic [DATA_W-1:0] sfrRdata, // peripheral read data
    output bmd_sfr_req_t sfrReq, // peripheral access
    output logic [DATA_W-1:0] memRdata, // read result
    output logic memRvalid, // read result strobe
    output logic [DATA_W-1:0] ptrValue, // pointer register
    output logic [DATA_W-1:0] optionValue, // option register
    output logic [DATA_W-1:0] portADir, // port a direction
    output logic [DATA_W-1:0] portBDir, // port b direction
    output logic [DATA_W-1:0] portCDir, // port c direction
    output logic [DATA_W-1:0] irCtrl, // infrared control
    output logic [DATA_W-1:0] infrared_cycle, // infrared cycle
    output logic [DATA_W-1:0] infrared_duty, // infrared duty
    output logic [DATA_W-1:0] irCarrier // infrared carrier period
);
    logic bankEn;
    logic [DATA_W-1:0] ptr_reg;
    logic [DATA_W-1:0] ptr_next;
    logic [DATA_W-1:0] option_reg;
    logic [DATA_W-1:0] dirA_reg;
    logic [DATA_W-1:0] dirB_reg;
    logic [DATA_W-1:0] dirC_reg;
    logic [DATA_W-1:0] irCtrl_reg;
    logic [DATA_W-1:0] infrared_cycle_reg;
    logic [DATA_W-1:0] infrared_duty_reg;
    logic [DATA_W-1:0] irCarrier_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic rvalid_reg;
    logic [1:0] bank;
    logic indirect;
    logic [ADDR_W-1:0] effAddr;
    bmd_loc_t loc;
    logic gprWe;
    logic [DATA_W-1:0] gprRdata;
    logic [DATA_W-1:0] spcRdata;

    // config bit passes two flops
    bmd_sync2 #(.W(1)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .din(cfgBankingEn),
        .dout(bankEn)
    );

    // maps bank and location onto pointer, peripheral or storage
    function automatic bmd_loc_t decodeLoc(input logic [1:0] bk,
                                           input logic [ADDR_W-1:0] a,
                                           input logic en);
        bmd_loc_t r;
        logic [4:0] off;
        r = '{kind: TGT_SFR, readOnly: 1'b0, sfr: a[4:0], gpr: '0};
        off = 5'(a - LOC_BANKED_LO);
        if (a == LOC_POINTER) begin
            r.kind = TGT_PTR;
        end else if (a >= LOC_BANK_GPR) begin
            r.kind = TGT_GPR;
            r.gpr = GPR_IDX_W'(SHARED_GPR_N) + GPR_IDX_W'(bk) * 8'h20
                    + GPR_IDX_W'(a - LOC_BANK_GPR);
        end else if (a >= LOC_SHARED_GPR) begin
            r.kind = TGT_GPR;
            r.gpr = GPR_IDX_W'(a - LOC_SHARED_GPR);
        end else if (a >= LOC_BANKED_LO && a <= LOC_BANKED_HI && en) begin
            if (bk == BANK_TIMER) begin
                r.sfr = SFR_TIMER_BASE + off;
                if (a == LOC_TIMER_GAP) begin
                    r.kind = TGT_NONE;
                end
            end else if (bk == BANK_SERIAL) begin
                r.sfr = SFR_SERIAL_BASE + off;
                r.readOnly = (a == LOC_SERIAL_RX);
            end
        end
        // otherwise the slot keeps its bank 0 code
        return r;
    endfunction

    // bank from the top pointer bits
    assign bank = ptr_reg[7:PTR_BANK_LO];
    // location zero redirects through the pointer
    assign indirect = (memAddr == LOC_INDIRECT);
    // low six pointer bits address the bank
    assign effAddr = indirect ? ptr_reg[ADDR_W-1:0] : memAddr;

    always_comb begin
        loc = decodeLoc(bank, effAddr, bankEn);
        // pointer to itself via location zero: read 0, write dropped
        if (effAddr == LOC_INDIRECT) begin
            loc.kind = TGT_NONE;
        end
    end

    assign gprWe = memWe && (loc.kind == TGT_GPR);

    bmd_gpr_store #(
        .DEPTH(GPR_DEPTH),
        .W(DATA_W),
        .IDX_W(GPR_IDX_W)
    ) u_store (
        .clk(clk),
        .wrEn(gprWe),
        .wrIdx(loc.gpr),
        .wrData(memWdata),
        .rdIdx(loc.gpr),
        .rdData(gprRdata)
    );

    always_comb begin
        sfrReq.we = memWe && (loc.kind == TGT_SFR) && !loc.readOnly;
        sfrReq.re = memRe && (loc.kind == TGT_SFR);
        sfrReq.sel = loc.sfr;
        sfrReq.wdata = memWdata;
    end

    always_comb begin
        ptr_next = ptr_reg;
        // pointer write is the general bank path
        if (memWe && loc.kind == TGT_PTR) begin
            ptr_next = memWdata;
        end
        // bank instruction wins bits 7:6 over a same-cycle write; its low six bits still land
        if (bankSetEn) begin
            ptr_next[7:PTR_BANK_LO] = bankSetVal;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ptr_reg <= PTR_RST;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            option_reg <= OPTION_RST;
        end else if (optWe) begin
            option_reg <= memWdata & OPTION_WR_MASK;
        end
    end

    // direction and infrared set by index
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dirA_reg <= DIR_RST;
            dirB_reg <= DIR_RST;
            dirC_reg <= DIR_RST;
            irCtrl_reg <= IR_RST;
            infrared_cycle_reg <= IR_RST;
            infrared_duty_reg <= IR_RST;
            irCarrier_reg <= IR_RST;
        end else if (dirWe) begin
            case (dirAddr)
                SPC_PORT_A_DIR: dirA_reg <= memWdata;
                SPC_PORT_B_DIR: dirB_reg <= memWdata;
                SPC_PORT_C_DIR: dirC_reg <= memWdata;
                // unused control bits held at zero
                SPC_IR_CTRL: irCtrl_reg <= memWdata & IR_CTRL_MASK;
                SPC_IR_CYCLE: infrared_cycle_reg <= memWdata;
                SPC_IR_DUTY: infrared_duty_reg <= memWdata;
                SPC_IR_CARRIER: irCarrier_reg <= memWdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (dirAddr)
            SPC_PORT_A_DIR: spcRdata = dirA_reg;
            SPC_PORT_B_DIR: spcRdata = dirB_reg;
            SPC_PORT_C_DIR: spcRdata = dirC_reg;
            SPC_IR_CTRL: spcRdata = irCtrl_reg & IR_CTRL_MASK;
            SPC_IR_CYCLE: spcRdata = infrared_cycle_reg;
            SPC_IR_DUTY: spcRdata = infrared_duty_reg;
            SPC_IR_CARRIER: spcRdata = irCarrier_reg;
            default: spcRdata = '0;
        endcase
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (optRe) begin
            rdata_next = option_reg | OPTION_RD_ONES;
        end else if (dirRe) begin
            rdata_next = spcRdata;
        end else if (memRe) begin
            case (loc.kind)
                TGT_PTR: rdata_next = ptr_reg;
                TGT_SFR: rdata_next = sfrRdata;
                TGT_GPR: rdata_next = gprRdata;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rvalid_reg <= memRe || optRe || dirRe;
        end
    end

    assign memRdata = rdata_reg;
    assign memRvalid = rvalid_reg;
    assign ptrValue = ptr_reg;
    assign optionValue = option_reg | OPTION_RD_ONES;
    assign portADir = dirA_reg;
    assign portBDir = dirB_reg;
    assign portCDir = dirC_reg;
    assign irCtrl = irCtrl_reg;
    assign infrared_cycle = infrared_cycle_reg;
    assign infrared_duty = infrared_duty_reg;
    assign irCarrier = irCarrier_reg;

    sequence readDone;
        ##1 memRvalid;
    endsequence

    sequence zeroResult;
        memRdata == 8'h00;
    endsequence

    bank_select_a: assert property (
        @(posedge clk) disable iff (!rstn)
        memRe && !optRe && !dirRe && effAddr >= LOC_BANK_GPR |->
        loc.gpr == GPR_IDX_W'(SHARED_GPR_N) + 8'(ptr_reg[7:6]) * 8'h20
                   + 8'(effAddr - LOC_BANK_GPR))
        else $error("bank index not from pointer bits");

    bank_hold_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !bankSetEn && !(memWe && loc.kind == TGT_PTR)
        |=> $stable(ptr_reg[7:6]))
        else $error("bank changed without pointer write");

    bank_instr_a: assert property (
        @(posedge clk) disable iff (!rstn)
        bankSetEn |=> ptr_reg[7:6] == $past(bankSetVal) && memRvalid ==
        $past(memRe || optRe || dirRe))
        else $error("bank instruction not applied");

    self_ref_a: assert property (
        @(posedge clk) disable iff (!rstn)
        memRe && !optRe && !dirRe && indirect && ptr_reg[5:0] == 6'h00
        |-> readDone ##0 zeroResult)
        else $error("pointer self read not zero");

    banked_on_a: assert property (
        @(posedge clk) disable iff (!rstn)
        sfrReq.re && bankEn && bank == BANK_SERIAL &&
        effAddr >= LOC_BANKED_LO && effAddr <= LOC_BANKED_HI
        |-> sfrReq.sel == SFR_SERIAL_BASE + 5'(effAddr - LOC_BANKED_LO))
        else $error("serial slot not decoded");

    banked_off_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (sfrReq.re || sfrReq.we) && !bankEn |-> sfrReq.sel == effAddr[4:0])
        else $error("disabled slot not folded to bank 0");

    special_iso_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (optWe || dirWe) && !memWe |-> !sfrReq.we && !gprWe
        ##1 $stable(ptr_reg[5:0]))
        else $error("special write leaked into data map");

    option_top_a: assert property (
        @(posedge clk) disable iff (!rstn)
        optRe |-> readDone ##0 memRdata[7] && memRdata[6:0] ==
        option_reg[6:0])
        else $error("option read bits wrong");

    ir_unused_a: assert property (
        @(posedge clk) disable iff (!rstn)
        dirRe && !optRe && dirAddr == SPC_IR_CTRL |=> memRdata[3:2] == 2'h0)
        else $error("infrared unused bits not zero");

    store_range_a: assert property (
        @(posedge clk) disable iff (!rstn)
        gprWe |-> int'(loc.gpr) < GPR_DEPTH)
        else $error("storage index outside range");

    shared_alias_a: assert property (
        @(posedge clk) disable iff (!rstn)
        gprWe && effAddr < LOC_BANK_GPR |->
        loc.gpr == 8'(effAddr - LOC_SHARED_GPR))
        else $error("shared storage not aliased to bank 0");

    serial_rx_a: assert property (
        @(posedge clk) disable iff (!rstn)
        memWe && bankEn && bank == BANK_SERIAL && effAddr == LOC_SERIAL_RX
        |-> !sfrReq.we)
        else $error("serial receive buffer took a write");

    timer_gap_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (memRe || memWe) && bankEn && bank == BANK_TIMER &&
        effAddr == LOC_TIMER_GAP |-> !sfrReq.re && !sfrReq.we && !gprWe)
        else $error("timer gap slot reached a register");

    plain_bank_a: assert property (
        @(posedge clk) disable iff (!rstn)
        sfrReq.re && bank != BANK_TIMER && bank != BANK_SERIAL
        |-> sfrReq.sel == effAddr[4:0])
        else $error("bank 0 or 2 slot not on bank 0 code");

    ptr_write_a: assert property (
        @(posedge clk) disable iff (!rstn)
        memWe && loc.kind == TGT_PTR && !bankSetEn
        |=> ptr_reg == $past(memWdata))
        else $error("pointer write not stored");

    option_write_a: assert property (
        @(posedge clk) disable iff (!rstn)
        optWe |=> option_reg == ($past(memWdata) & OPTION_WR_MASK))
        else $error("option write not stored");

    dir_write_a: assert property (
        @(posedge clk) disable iff (!rstn)
        dirWe && dirAddr == SPC_PORT_A_DIR |=> portADir == $past(memWdata))
        else $error("port a direction write not stored");

    store_read_a: assert property (
        @(posedge clk) disable iff (!rstn)
        memRe && !optRe && !dirRe && loc.kind == TGT_GPR
        |=> memRvalid && memRdata == $past(gprRdata))
        else $error("storage read result wrong");
endmodule

/* verif/bmd_periph_model.sv */
`timescale 1ns/10ps
module bmd_periph_model import bmd_pkg::*; (
    input wire logic clk, // system clock
    input wire bmd_sfr_req_t sfrReq, // peripheral access
    output logic [DATA_W-1:0] sfrRdata // read answer, same cycle
);
    logic [DATA_W-1:0] regs [32];
    logic [DATA_W-1:0] idle_reg;
    initial begin
        idle_reg = 8'h00;
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
        end
    end
    always @(posedge clk) begin
        idle_reg <= idle_reg + 8'h3b;
        if (sfrReq.we) begin
            regs[sfrReq.sel] <= sfrReq.wdata;
        end
    end
    // no read strobe: bus shows a moving pattern, not the last value
    assign sfrRdata = sfrReq.re ? regs[sfrReq.sel] : ~idle_reg;
endmodule

/* verif/banked_data_memory_decoder_bench.sv */
`timescale 1ns/10ps
module banked_data_memory_decoder_bench import bmd_pkg::*;;
    logic clk, rstn, cfgBankingEn, optWe, optRe, dirWe, dirRe;
    logic memWe, memRe, bankSetEn, memRvalid, reSeen;
    logic [6:0] strb;
    logic [1:0] bankSetVal;
    logic [5:0] memAddr;
    logic [3:0] dirAddr;
    logic [4:0] selSeen, s;
    logic [7:0] memWdata, sfrRdata, memRdata, ptrValue, optionValue, d;
    logic [7:0] portADir, portBDir, portCDir, irCtrl, infrared_cycle, infrared_duty;
    logic [7:0] irCarrier;
    logic [7:0] psh [32];
    logic [7:0] gv [4];
    logic [7:0] dv [7];
    logic [3:0] dl [7] = '{4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
    bmd_sfr_req_t sfrReq;
    int nFail = 0;
    int comparisons = 0;
    int seedVal;
    bit none;
    assign {bankSetEn, dirRe, dirWe, optRe, optWe, memRe, memWe} = strb;
    bmd_decoder dut_u (.clk(clk), .rstn(rstn), .cfgBankingEn(cfgBankingEn),
        .memWe(memWe), .memRe(memRe), .memAddr(memAddr),
        .memWdata(memWdata), .bankSetEn(bankSetEn), .bankSetVal(bankSetVal),
        .optWe(optWe), .optRe(optRe), .dirWe(dirWe), .dirRe(dirRe),
        .dirAddr(dirAddr), .sfrRdata(sfrRdata), .sfrReq(sfrReq),
        .memRdata(memRdata), .memRvalid(memRvalid), .ptrValue(ptrValue),
        .optionValue(optionValue), .portADir(portADir),
        .portBDir(portBDir), .portCDir(portCDir), .irCtrl(irCtrl),
        .infrared_cycle(infrared_cycle), .infrared_duty(infrared_duty), .irCarrier(irCarrier));
    bmd_periph_model peer_u (.clk(clk), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test;
        $display("comparisons=%0d nFail=%0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkSel(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] t=%0t sel=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [4:0] expSel(input int en, input int b,
                                          input int a);
        logic [4:0] off;
        off = 5'(a - int'(LOC_BANKED_LO));
        if (en == 1 && b == int'(BANK_TIMER)) begin
            return SFR_TIMER_BASE + off;
        end
        if (en == 1 && b == int'(BANK_SERIAL)) begin
            return SFR_SERIAL_BASE + off;
        end
        return 5'(a);
    endfunction
    // k: 0 wr 1 rd 2 optWr 3 optRd 4 dirWr 5 dirRd 6 bank instr
    task automatic op(input int k, input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        strb <= 7'(1 << k);
        memAddr <= a;
        dirAddr <= a[3:0];
        memWdata <= v;
        bankSetVal <= v[7:6];
        #1;
        selSeen = sfrReq.sel;
        reSeen = sfrReq.re;
        @(posedge clk);
        strb <= '0;
        #1;
        if (k == 1 || k == 3 || k == 5) begin
            chk({7'h0, memRvalid}, 8'h01);
        end
    endtask
    initial begin
        rstn = 1'b0;
        cfgBankingEn = 1'b0;
        strb = '0;
        memAddr = '0;
        dirAddr = '0;
        memWdata = '0;
        bankSetVal = '0;
        for (int i = 0; i < 32; i++) begin
            psh[i] = 8'(i) ^ 8'h5a;
        end
        seedVal = $urandom(32'hb015fabf);
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(ptrValue, PTR_RST);
        chk(optionValue, 8'hff);
        chk(portBDir, DIR_RST);
        chk(infrared_duty, IR_RST);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            d = 8'($urandom);
            dv[i] = d;
            op(4, {2'h0, dl[i]}, d);
            op(5, {2'h0, dl[i]}, 8'h00);
            chk(memRdata, dl[i] == 4'hc ? d & IR_CTRL_MASK : d);
        end
        chk(portADir, dv[0]);
        chk(portBDir, dv[1]);
        chk(portCDir, dv[2]);
        chk(irCtrl, dv[3] & IR_CTRL_MASK);
        chk(infrared_cycle, dv[4]);
        chk(infrared_duty, dv[5]);
        chk(irCarrier, dv[6]);
        op(4, 6'h04, 8'h77);
        op(5, 6'h04, 8'h00);
        chk(memRdata, 8'h00);
        op(2, 6'h00, 8'h00);
        op(3, 6'h00, 8'h00);
        chk(memRdata, 8'h80);
        $display("test special done");
        for (int b = 0; b < 4; b++) begin
            op(0, LOC_POINTER, {2'(b), 6'h25});
            chk(ptrValue, {2'(b), 6'h25});
            op(6, 6'h00, {~2'(b), 6'h00});
            chk(ptrValue, {~2'(b), 6'h25});
            op(1, LOC_POINTER, 8'h00);
            chk(memRdata, {~2'(b), 6'h25});
        end
        $display("test bank done");
        for (int b = 0; b < 4; b++) begin
            gv[b] = 8'($urandom);
            op(6, 6'h00, {2'(b), 6'h00});
            op(0, 6'h2a, gv[b]);
        end
        for (int b = 0; b < 4; b++) begin
            op(0, LOC_POINTER, {2'(b), 6'h2a});
            op(1, LOC_INDIRECT, 8'h00);
            chk(memRdata, gv[b]);
        end
        op(0, LOC_POINTER, 8'hb1);
        op(0, LOC_INDIRECT, 8'h3c);
        op(6, 6'h00, 8'h80);
        op(1, 6'h31, 8'h00);
        chk(memRdata, 8'h3c);
        op(6, 6'h00, 8'h00);
        op(0, 6'h15, 8'hc3);
        op(6, 6'h00, 8'hc0);
        op(1, 6'h15, 8'h00);
        chk(memRdata, 8'hc3);
        op(0, LOC_POINTER, 8'h40);
        op(1, LOC_INDIRECT, 8'h00);
        chk(memRdata, 8'h00);
        $display("test storage done");
        for (int en = 0; en < 2; en++) begin
            @(posedge clk);
            cfgBankingEn <= 1'(en);
            repeat (4) @(posedge clk);
            for (int b = 0; b < 4; b++) begin
                op(6, 6'h00, {2'(b), 6'h00});
                for (int a = 11; a < 15; a++) begin
                    none = en == 1 && b == 1 && a == 14;
                    s = expSel(en, b, a);
                    d = 8'($urandom);
                    op(0, 6'(a), d);
                    if (!none && !(en == 1 && b == 3 && a == 11)) psh[s] = d;
                    op(1, 6'(a), 8'h00);
                    if (none) begin
                        chk({7'h0, reSeen}, 8'h00);
                        chk(memRdata, 8'h00);
                    end else begin
                        chkSel(selSeen, s);
                        chk(memRdata, psh[s]);
                    end
                end
            end
        end
        $display("test banked done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(memRdata, 8'h00);
        chk({7'h0, memRvalid}, 8'h00);
        chk(ptrValue, PTR_RST);
        chk(portCDir, DIR_RST);
        chk(irCtrl, IR_RST);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        op(3, 6'h00, 8'h00);
        chk(memRdata, OPTION_RST | OPTION_RD_ONES);
        $display("test midreset done");
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        finish_test();
    end
endmodule
